// ---- shared/rlm_pkg.sv ----
// Constants, register map and state encoding of the read latency monitor
// Contract
// - ID map low half shows usable IDs
// - Enabled monitor times reads, address to data
// - Control bit picks first or last beat
// - Count samples; count late when latency >= limit
// - Add each latency into running total
// - After each check, time the next read
// - Suspend on saturation or control register read
// - Latency total read clears counters, resumes
// - Limit and counters writable only while disabled
// - Counter test keeps counters on enable/resume
// - Timer test starts timer at preload value
// - Timer saturates at terminal value, holds
// - Timer field shows latest read, writable disabled
// - Late count is 20 bits, suspends at ones
// - Legacy and new addresses alias same fields
// - Control and late count reset to zero
// - Sample count is 20-bit own register
// - Separate register holds latency total
package rlm_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned TIMER_W = 12;
	localparam int unsigned CNT_W = 20;
	localparam int unsigned SUM_W = 28;
	localparam int unsigned ID_W = 4;
	localparam int unsigned ID_NUM = 16;

	localparam logic [ADDR_W-1:0] OFF_ID_MAP = 12'h524;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h530;
	localparam logic [ADDR_W-1:0] OFF_LATE = 12'h534;
	localparam logic [ADDR_W-1:0] OFF_SAMPLE = 12'h538;
	localparam logic [ADDR_W-1:0] OFF_SUM = 12'h53C;
	localparam logic [ADDR_W-1:0] OFF_LEG_ID_MAP = 12'h250;
	localparam logic [ADDR_W-1:0] OFF_LEG_CTRL = 12'h260;
	localparam logic [ADDR_W-1:0] OFF_LEG_SUM = 12'h264;

	localparam int unsigned BIT_ENABLE = 31;
	localparam int unsigned BIT_CNT_TEST = 30;
	localparam int unsigned BIT_TMR_TEST = 29;
	localparam int unsigned BIT_LAST_BEAT = 28;
	localparam int unsigned LIMIT_LSB = 16;
	localparam int unsigned LIMIT_MSB = 27;
	localparam int unsigned TIMER_LSB = 0;
	localparam int unsigned TIMER_MSB = 11;

	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
	localparam logic [TIMER_W-1:0] TIMER_ONE = 12'h001;
	localparam logic [TIMER_W-1:0] TIMER_PRELOAD = 12'hFF0;
	localparam logic [TIMER_W-1:0] TIMER_TERMINAL = 12'hFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h0_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 20'h0_0001;
	localparam logic [CNT_W-1:0] CNT_MAX = 20'hF_FFFF;
	localparam logic [SUM_W-1:0] SUM_ZERO = 28'h000_0000;
	localparam logic [SUM_W-1:0] SUM_MAX = 28'hFFF_FFFF;
	localparam logic [ID_NUM-1:0] ID_MAP_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEASURE = 2'b01,
		ST_TALLY = 2'b11
	} mon_state_t;

endpackage : rlm_pkg

// ---- shared/reg_access_if.sv ----
// Register access strobes between the APB port and the register file
`timescale 1ns/1ps
interface reg_access_if;
	import rlm_pkg::*;
	logic wr_stb;
	logic rd_stb;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic hit;
	modport slave(output wr_stb, output rd_stb, output addr, output wdata,
		input rdata, input hit);
	modport regs(input wr_stb, input rd_stb, input addr, input wdata,
		output rdata, output hit);
endinterface : reg_access_if

// ---- hdl/apb_port.sv ----
// APB slave handshake, one wait state, registered read data
`timescale 1ns/1ps
module apb_port import rlm_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Register side
	reg_access_if.slave bus
);
	logic access;
	logic wait_q;
	logic hit_q;

	assign access = psel_i & penable_i;
	assign pready_o = access & wait_q;
	assign pslverr_o = pready_o & ~hit_q;
	assign bus.addr = paddr_i;
	assign bus.wdata = pwdata_i;
	// Read side effects fire once, in the first access cycle
	assign bus.rd_stb = access & ~wait_q & ~pwrite_i;
	assign bus.wr_stb = pready_o & pwrite_i & hit_q;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_q <= 1'b0;
		end else if (pready_o) begin
			wait_q <= 1'b0;
		end else if (access) begin
			wait_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hit_q <= 1'b0;
			prdata_o <= RST_WORD;
		end else if (access & ~wait_q) begin
			hit_q <= bus.hit;
			prdata_o <= (pwrite_i | ~bus.hit) ? RST_WORD : bus.rdata;
		end
	end

endmodule : apb_port

// ---- hdl/check_timer.sv ----
// Per-check 12-bit latency timer with preload and saturation
`timescale 1ns/1ps
module check_timer import rlm_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic start_i,
	input wire logic run_i,
	input wire logic preload_i,
	input wire logic load_i,
	input wire logic [TIMER_W-1:0] load_val_i,
	// Value
	output logic [TIMER_W-1:0] count_o
);
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_o <= TIMER_ZERO;
		end else if (start_i) begin
			count_o <= preload_i ? TIMER_PRELOAD : TIMER_ZERO;
		end else if (load_i) begin
			count_o <= load_val_i;
		end else if (run_i && count_o != TIMER_TERMINAL) begin
			count_o <= count_o + TIMER_ONE;
		end
	end

endmodule : check_timer

// ---- hdl/axi_read_latency_monitor.sv ----
// AXI read latency monitor: register file, measurement control, counters
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module axi_read_latency_monitor import rlm_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Observed AXI read address channel
	input wire logic arvalid_i,
	input wire logic arready_i,
	input wire logic [ID_W-1:0] arid_i,
	// Observed AXI read data channel
	input wire logic rvalid_i,
	input wire logic rready_i,
	input wire logic [ID_W-1:0] rid_i,
	input wire logic rlast_i,
	// Hardwired ID availability
	input wire logic [ID_NUM-1:0] id_usable_i,
	// Status
	output logic check_busy_o,
	output logic suspended_o
);
	reg_access_if regs_bus();

	mon_state_t state_q;
	logic [ID_NUM-1:0] id_meta_q;
	logic [ID_NUM-1:0] id_usable_q;
	logic enable_q;
	logic cnt_test_q;
	logic tmr_test_q;
	logic last_beat_q;
	logic [TIMER_W-1:0] limit_q;
	logic [CNT_W-1:0] late_q;
	logic [CNT_W-1:0] sample_q;
	logic [SUM_W-1:0] sum_q;
	logic [ID_W-1:0] cur_id_q;
	logic [CNT_W-1:0] late_d;
	logic [CNT_W-1:0] sample_d;
	logic [SUM_W-1:0] sum_d;
	logic enable_d;
	logic [TIMER_W-1:0] latency;

	logic ctrl_sel;
	logic late_sel;
	logic sample_sel;
	logic sum_sel;
	logic map_sel;
	logic wr_ctrl;
	logic rd_ctrl;
	logic rd_sum;
	logic fields_open;
	logic enable_rise;
	logic clr_cnt;
	logic resume;
	logic sat_d;
	logic ar_hs;
	logic end_hs;
	logic start;
	logic tally;
	logic is_late;
	logic [SUM_W:0] sum_ext;

	apb_port u_apb (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.bus(regs_bus)
	);

	check_timer u_timer (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.start_i(start),
		.run_i(state_q == ST_MEASURE),
		.preload_i(tmr_test_q),
		.load_i(wr_ctrl & fields_open),
		.load_val_i(regs_bus.wdata[TIMER_MSB:TIMER_LSB]),
		.count_o(latency)
	);

	// Hardwired strap pins, two stages before use
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_meta_q <= ID_MAP_ZERO;
			id_usable_q <= ID_MAP_ZERO;
		end else begin
			id_meta_q <= id_usable_i;
			id_usable_q <= id_meta_q;
		end
	end

	// Address decode; legacy window lands on the same flops
	assign ctrl_sel = (regs_bus.addr == OFF_CTRL) || (regs_bus.addr == OFF_LEG_CTRL);
	assign sum_sel = (regs_bus.addr == OFF_SUM) || (regs_bus.addr == OFF_LEG_SUM);
	assign map_sel = (regs_bus.addr == OFF_ID_MAP) || (regs_bus.addr == OFF_LEG_ID_MAP);
	assign late_sel = regs_bus.addr == OFF_LATE;
	assign sample_sel = regs_bus.addr == OFF_SAMPLE;
	assign regs_bus.hit = ctrl_sel | sum_sel | map_sel | late_sel | sample_sel;

	assign wr_ctrl = regs_bus.wr_stb & ctrl_sel;
	assign rd_ctrl = regs_bus.rd_stb & ctrl_sel & enable_q;
	assign rd_sum = regs_bus.rd_stb & sum_sel & enable_q;
	assign fields_open = ~enable_q;
	assign enable_d = wr_ctrl ? regs_bus.wdata[BIT_ENABLE] : enable_q;
	assign enable_rise = enable_d & ~enable_q;
	assign resume = rd_sum | enable_rise;
	// Counter test keeps preloaded values across enable and resume
	assign clr_cnt = enable_rise ? ~regs_bus.wdata[BIT_CNT_TEST] :
		(rd_sum & ~cnt_test_q);

	always_comb begin
		regs_bus.rdata = RST_WORD;
		if (ctrl_sel) begin
			regs_bus.rdata[BIT_ENABLE] = enable_q;
			regs_bus.rdata[BIT_CNT_TEST] = cnt_test_q;
			regs_bus.rdata[BIT_TMR_TEST] = tmr_test_q;
			regs_bus.rdata[BIT_LAST_BEAT] = last_beat_q;
			regs_bus.rdata[LIMIT_MSB:LIMIT_LSB] = limit_q;
			regs_bus.rdata[TIMER_MSB:TIMER_LSB] = latency;
		end else if (late_sel) begin
			regs_bus.rdata[CNT_W-1:0] = late_q;
		end else if (sample_sel) begin
			regs_bus.rdata[CNT_W-1:0] = sample_q;
		end else if (sum_sel) begin
			regs_bus.rdata[SUM_W-1:0] = sum_q;
		end else if (map_sel) begin
			regs_bus.rdata[ID_NUM-1:0] = id_usable_q;
		end
	end

	// Control fields; mode bits stay writable while enabled
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enable_q <= RST_WORD[BIT_ENABLE];
			cnt_test_q <= RST_WORD[BIT_CNT_TEST];
			tmr_test_q <= RST_WORD[BIT_TMR_TEST];
			last_beat_q <= RST_WORD[BIT_LAST_BEAT];
		end else if (wr_ctrl) begin
			enable_q <= regs_bus.wdata[BIT_ENABLE];
			cnt_test_q <= regs_bus.wdata[BIT_CNT_TEST];
			tmr_test_q <= regs_bus.wdata[BIT_TMR_TEST];
			last_beat_q <= regs_bus.wdata[BIT_LAST_BEAT];
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			limit_q <= RST_WORD[LIMIT_MSB:LIMIT_LSB];
		end else if (wr_ctrl & fields_open) begin
			limit_q <= regs_bus.wdata[LIMIT_MSB:LIMIT_LSB];
		end
	end

	// Measurement sequencing
	assign ar_hs = arvalid_i & arready_i;
	assign end_hs = rvalid_i & rready_i & (rid_i == cur_id_q)
		& (~last_beat_q | rlast_i);
	// Only an idle monitor takes a new read; later reads pass unsampled
	assign start = (state_q == ST_IDLE) & enable_q & ~suspended_o & ar_hs;
	assign tally = (state_q == ST_TALLY) & enable_q;
	assign is_late = latency >= limit_q;
	assign check_busy_o = state_q == ST_MEASURE;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_MEASURE;
					end
				end
				ST_MEASURE: begin
					// Abort drops the sample rather than tally a stale one
					if (~enable_q | suspended_o) begin
						state_q <= ST_IDLE;
					end else if (end_hs) begin
						state_q <= ST_TALLY;
					end
				end
				ST_TALLY: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cur_id_q <= '0;
		end else if (start) begin
			cur_id_q <= arid_i;
		end
	end

	// Next counter values; a tally in the clearing cycle is kept
	always_comb begin
		late_d = clr_cnt ? CNT_ZERO : late_q;
		sample_d = clr_cnt ? CNT_ZERO : sample_q;
		sum_d = clr_cnt ? SUM_ZERO : sum_q;
		sum_ext = {1'b0, sum_d} + {{(SUM_W-TIMER_W+1){1'b0}}, latency};
		if (fields_open && regs_bus.wr_stb && late_sel) begin
			late_d = regs_bus.wdata[CNT_W-1:0];
		end else if (tally && is_late && late_d != CNT_MAX) begin
			late_d = late_d + CNT_ONE;
		end
		if (fields_open && regs_bus.wr_stb && sample_sel) begin
			sample_d = regs_bus.wdata[CNT_W-1:0];
		end else if (tally && sample_d != CNT_MAX) begin
			sample_d = sample_d + CNT_ONE;
		end
		if (fields_open && regs_bus.wr_stb && sum_sel) begin
			sum_d = regs_bus.wdata[SUM_W-1:0];
		end else if (tally) begin
			// Saturate so the total never wraps past its stop value
			sum_d = (sum_ext >= {1'b0, SUM_MAX}) ? SUM_MAX : sum_ext[SUM_W-1:0];
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			late_q <= CNT_ZERO;
			sample_q <= CNT_ZERO;
			sum_q <= SUM_ZERO;
		end else begin
			late_q <= late_d;
			sample_q <= sample_d;
			sum_q <= sum_d;
		end
	end

	// Suspension: set wins over resume in the same cycle
	assign sat_d = (sample_d == CNT_MAX) | (late_d == CNT_MAX) | (sum_d == SUM_MAX);

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			suspended_o <= 1'b0;
		end else begin
			suspended_o <= enable_d & ((suspended_o & ~resume) | rd_ctrl | sat_d);
		end
	end

endmodule : axi_read_latency_monitor

// ---- tb/rlm_chk.sv ----
// Port-level assertions for the read latency monitor
`timescale 1ns/1ps
module rlm_chk import rlm_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	input wire logic [DATA_W-1:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// AXI read channels
	input wire logic arvalid_i,
	input wire logic arready_i,
	input wire logic [ID_W-1:0] arid_i,
	input wire logic rvalid_i,
	input wire logic rready_i,
	input wire logic [ID_W-1:0] rid_i,
	input wire logic rlast_i,
	input wire logic [ID_NUM-1:0] id_usable_i,
	// Status
	input wire logic check_busy_o,
	input wire logic suspended_o
);
	logic mapped;
	logic [ID_W-1:0] id_q;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	assign mapped = paddr_i inside {OFF_ID_MAP, OFF_CTRL, OFF_LATE, OFF_SAMPLE, OFF_SUM,
		OFF_LEG_ID_MAP, OFF_LEG_CTRL, OFF_LEG_SUM};
	// Tracks the ID under measurement; ARs seen while busy are not sampled
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_q <= '0;
		end else if (arvalid_i && arready_i && !check_busy_o) begin
			id_q <= arid_i;
		end
	end
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_access;
		psel_i && penable_i;
	endsequence
	a_one_wait: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
		else $error("pready not in second access cycle");
	a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("pready outside access");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	a_err_decode: assert property (pready_o |-> pslverr_o == !mapped)
		else $error("slave error does not match decode");
	a_zero_rdata: assert property (pready_o && (pwrite_i || pslverr_o) |-> prdata_o == RST_WORD)
		else $error("read data not zero");
	a_busy_start: assert property ($rose(check_busy_o) |-> $past(arvalid_i && arready_i))
		else $error("measurement began without address handshake");
	a_busy_end: assert property (check_busy_o && rvalid_i && rready_i && rlast_i && rid_i == id_q
		|=> !check_busy_o)
		else $error("measurement did not end on last beat");
	a_susp_hold: assert property (suspended_o && !(psel_i && (pwrite_i || paddr_i == OFF_SUM
		|| paddr_i == OFF_LEG_SUM)) |=> suspended_o)
		else $error("suspension dropped without cause");
	a_susp_idle: assert property (suspended_o && $past(suspended_o) |-> !check_busy_o)
		else $error("measuring while suspended");
endmodule : rlm_chk

// ---- tb/axi_rd_slave.sv ----
// Far-side AXI read model: address handshake, then data beats after a gap
`timescale 1ns/1ps
module axi_rd_slave import rlm_pkg::*; (
	// Clock
	input wire logic core_clk_i,
	// AXI read channels
	output logic arvalid_o,
	output logic arready_o,
	output logic [ID_W-1:0] arid_o,
	output logic rvalid_o,
	output logic rready_o,
	output logic [ID_W-1:0] rid_o,
	output logic rlast_o
);
	initial begin
		arvalid_o = 1'b0;
		arready_o = 1'b0;
		arid_o = '0;
		rvalid_o = 1'b0;
		rready_o = 1'b0;
		rid_o = '1;
		rlast_o = 1'b0;
	end
	// First beat lands gap cycles after the address handshake
	task read_txn(input logic [ID_W-1:0] id, input int gap, input int beats);
		int i;
		@(posedge core_clk_i);
		arvalid_o <= 1'b1;
		arready_o <= 1'b1;
		arid_o <= id;
		@(posedge core_clk_i);
		arvalid_o <= 1'b0;
		arready_o <= 1'b0;
		arid_o <= ~id;
		repeat (gap - 1) @(posedge core_clk_i);
		for (i = 0; i < beats; i++) begin
			rvalid_o <= 1'b1;
			rready_o <= 1'b1;
			rid_o <= id;
			rlast_o <= (i == beats - 1);
			@(posedge core_clk_i);
		end
		// Released ID shows a changed value, not the last one
		rvalid_o <= 1'b0;
		rready_o <= 1'b0;
		rid_o <= ~id;
		rlast_o <= 1'b0;
	endtask : read_txn
	// Second read issued while the first is timed; its beat comes first
	task overlap_txn(input logic [ID_W-1:0] id_a, input logic [ID_W-1:0] id_b);
		@(posedge core_clk_i);
		arvalid_o <= 1'b1;
		arready_o <= 1'b1;
		arid_o <= id_a;
		@(posedge core_clk_i);
		arid_o <= id_b;
		@(posedge core_clk_i);
		arvalid_o <= 1'b0;
		arready_o <= 1'b0;
		arid_o <= ~id_b;
		rvalid_o <= 1'b1;
		rready_o <= 1'b1;
		rid_o <= id_b;
		rlast_o <= 1'b1;
		@(posedge core_clk_i);
		rid_o <= id_a;
		@(posedge core_clk_i);
		rvalid_o <= 1'b0;
		rready_o <= 1'b0;
		rid_o <= ~id_a;
		rlast_o <= 1'b0;
	endtask : overlap_txn
endmodule : axi_rd_slave

// ---- tb/axi_read_latency_monitor_test.sv ----
// Register-level testbench of the read latency monitor
`timescale 1ns/1ps
module axi_read_latency_monitor_test import rlm_pkg::*;;
	logic core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, last_err;
	logic [ADDR_W-1:0] paddr_i;
	logic [DATA_W-1:0] pwdata_i, prdata_o;
	logic arvalid_i, arready_i, rvalid_i, rready_i, rlast_i, check_busy_o, suspended_o;
	logic [ID_W-1:0] arid_i, rid_i;
	logic [ID_NUM-1:0] id_usable_i;
	int err_count = 0;
	int n_compared = 0;
	axi_read_latency_monitor dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.arvalid_i(arvalid_i), .arready_i(arready_i), .arid_i(arid_i), .rvalid_i(rvalid_i),
		.rready_i(rready_i), .rid_i(rid_i), .rlast_i(rlast_i), .id_usable_i(id_usable_i),
		.check_busy_o(check_busy_o), .suspended_o(suspended_o));
	axi_rd_slave u_slv (.core_clk_i(core_clk_i), .arvalid_o(arvalid_i), .arready_o(arready_i),
		.arid_o(arid_i), .rvalid_o(rvalid_i), .rready_o(rready_i), .rid_o(rid_i),
		.rlast_o(rlast_i));
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	task final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			err_count++;
		end
	endtask : chk
	task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
		output logic [DATA_W-1:0] rd);
		int n;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		// A slave that never answers ends the run
		if (pready_o !== 1'b1) begin
			err_count++;
			final_report();
		end else begin
			rd = prdata_o;
			last_err = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
			// Idle edge so the next setup never re-drives psel in this step
			@(posedge core_clk_i);
		end
	endtask : apb
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] v;
		apb(1'b1, a, d, v);
	endtask : wr
	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] v;
		apb(1'b0, a, '0, v);
		chk(v, exp);
	endtask : rd
	task txn(input logic [ID_W-1:0] id, input int gap, input int beats);
		u_slv.read_txn(id, gap, beats);
		repeat (3) @(posedge core_clk_i);
	endtask : txn
	initial begin
		nrst_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = '0;
		pwdata_i = '0;
		id_usable_i = 16'hA5C3;
		repeat (20) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rd(OFF_CTRL, 32'h0000_0000);
		rd(OFF_LATE, 32'h0000_0000);
		rd(OFF_ID_MAP, 32'h0000_A5C3);
		rd(OFF_LEG_ID_MAP, 32'h0000_A5C3);
		rd(12'h528, 32'h0000_0000);
		chk(last_err, 1'b1);
		wr(OFF_LEG_CTRL, 32'h2ABC_0123);
		rd(OFF_CTRL, 32'h2ABC_0123);
		wr(OFF_LATE, 32'hFFFF_F005);
		rd(OFF_LATE, 32'h000F_F005);
		wr(OFF_CTRL, 32'h8003_0000);
		rd(OFF_LATE, 32'h0000_0000);
		txn(4'h1, 2, 1);
		txn(4'h2, 4, 3);
		wr(OFF_LATE, 32'h0000_0077);
		rd(OFF_LATE, 32'h0000_0001);
		rd(OFF_SAMPLE, 32'h0000_0002);
		rd(OFF_CTRL, 32'h8003_0004);
		chk(suspended_o, 1'b1);
		txn(4'h3, 2, 1);
		rd(OFF_SAMPLE, 32'h0000_0002);
		rd(OFF_SUM, 32'h0000_0006);
		chk(suspended_o, 1'b0);
		rd(OFF_SAMPLE, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'h9003_0000);
		txn(4'h4, 2, 3);
		rd(OFF_LATE, 32'h0000_0001);
		rd(OFF_LEG_SUM, 32'h0000_0004);
		u_slv.overlap_txn(4'h8, 4'h9);
		repeat (3) @(posedge core_clk_i);
		rd(OFF_LATE, 32'h0000_0001);
		rd(OFF_SAMPLE, 32'h0000_0001);
		rd(OFF_SUM, 32'h0000_0003);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'hA000_0000);
		txn(4'h5, 20, 1);
		rd(OFF_CTRL, 32'hA000_0FFF);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_SAMPLE, 32'h000F_FFFE);
		wr(OFF_CTRL, 32'hC000_0000);
		rd(OFF_SAMPLE, 32'h000F_FFFE);
		txn(4'h6, 1, 1);
		chk(suspended_o, 1'b1);
		rd(OFF_SAMPLE, 32'h000F_FFFF);
		final_report();
	end
endmodule : axi_read_latency_monitor_test
bind axi_read_latency_monitor rlm_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.arvalid_i(arvalid_i), .arready_i(arready_i), .arid_i(arid_i), .rvalid_i(rvalid_i),
	.rready_i(rready_i), .rid_i(rid_i), .rlast_i(rlast_i), .id_usable_i(id_usable_i),
	.check_busy_o(check_busy_o), .suspended_o(suspended_o));
